// ---- common/fbl_pkg.sv ----
package fbl_pkg;

  typedef enum logic [3:0] {
    FBL_RESET = 4'h1,
    FBL_LOAD = 4'h2,
    FBL_INIT = 4'h4,
    FBL_USER = 4'h8
  } fbl_state_type;

  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_KHZ = 40000;
  localparam int CD_LOW_MAX_NS = 600;
  localparam int CD_LOW_MAX_CYC = CD_LOW_MAX_NS / CLK_PERIOD_NS;
  localparam int STATUS_MIN_US = 268;
  localparam int STATUS_MIN_CYC = (STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_MAX_US = 1506;
  localparam int STATUS_MAX_CYC = STATUS_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int UM_MIN_US = 175;
  localparam int UM_MIN_CYC = (UM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UM_MAX_US = 437;
  localparam int UM_MAX_CYC = UM_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int CU_PERIOD_NS = 10;
  localparam int CU_PERIODS = 4;
  localparam int CU_CYC = (CU_PERIODS * CU_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int USR_INIT_EDGES = 8576;

  localparam int FL_KHZ0 = 12500;
  localparam int FL_KHZ1 = 25000;
  localparam int FL_KHZ2 = 50000;
  localparam int FL_KHZ3 = 100000;
  localparam int FL_HALF0 = (CLK_KHZ + 2 * FL_KHZ0 - 1) / (2 * FL_KHZ0);
  localparam int FL_HALF1 = (CLK_KHZ + 2 * FL_KHZ1 - 1) / (2 * FL_KHZ1);
  localparam int FL_HALF2 = (CLK_KHZ + 2 * FL_KHZ2 - 1) / (2 * FL_KHZ2);
  localparam int FL_HALF3 = (CLK_KHZ + 2 * FL_KHZ3 - 1) / (2 * FL_KHZ3);
  localparam logic [1:0] FL_SEL_TOP = 2'h3;
  localparam logic [1:0] FL_SEL_CHAIN = 2'h2;
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam logic [5:0] CMD_BITS = 6'h20;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LEN = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_CNT = 8'h0c;
  localparam logic [7:0] REG_WORD = 8'h10;
  localparam int CTRL_SCHEME = 0;
  localparam int CTRL_WIDTH = 1;
  localparam int CTRL_QUAD = 3;
  localparam int CTRL_USRCLK = 4;
  localparam int CTRL_INITEN = 5;
  localparam int CTRL_SECURE = 6;
  localparam int CTRL_CHAIN = 7;
  localparam int CTRL_FCLK = 8;
  localparam int CTRL_RATIO = 12;
  localparam int STAT_FAULT = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_1004;
  localparam logic [31:0] LEN_RST = 32'h0000_0010;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fbl_pkg

// ---- rtl/fbl_sequencer.sv ----
// Contract
// - Load complete goes low within 600 ns of the request falling.
// - Status line is pulled low within 600 ns of the request falling.
// - Status line stays low between 268 and 1506 us in reset.
// - Status line is released within 1506 us of the request rising.
// - Decompression or security forces a clock-to-word ratio above one; the code forces it for security (CTRL_SECURE) only.
// - Internal oscillator init reaches user mode 175 to 437 us after completion.
// - User init clock is ignored until four load clock periods after completion.
// - User clock init needs that delay plus 8576 user clock periods.
// - Init clock comes from internal oscillator or user clock, by option.
// - Flash clock offers 12.5, 25, 50 and 100 MHz ceilings.
// - A multi-device flash chain never uses the 100 MHz setting.
// - Quad flash mode takes 4 data bits per flash clock.
// - Flash command launches and flash data captures on falling clock edges.
// - With the option on, init done pin stays low until init ends.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fbl_sequencer #(
  parameter int STATUS_MIN_CYC_P = fbl_pkg::STATUS_MIN_CYC,
  parameter int UM_MIN_CYC_P = fbl_pkg::UM_MIN_CYC,
  parameter int USR_INIT_EDGES_P = fbl_pkg::USR_INIT_EDGES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic reconfig_request_n,
  input wire logic config_state_n_i,
  output logic config_state_n_o,
  output logic config_state_n_oe,
  output logic load_complete,
  input wire logic load_clock_i,
  output logic load_clock_o,
  output logic load_clock_oe,
  input wire logic [31:0] load_data,
  output logic flash_cmd_out,
  input wire logic [3:0] flash_data_lines,
  input wire logic user_init_clock,
  output logic init_done_o,
  output logic init_done_oe,
  output logic [31:0] loaded_word,
  output logic loaded_word_valid,
  output logic user_mode
);

  localparam int CD_MAX_CYC = fbl_pkg::CD_LOW_MAX_CYC;

  fbl_pkg::fbl_state_type state_r, state_nxt;
  logic [31:0] tmr_r, tmr_nxt, word_cnt_r, word_cnt_nxt, asm_r, asm_nxt, word_r, word_nxt;
  logic [31:0] cmd_sh_r, cmd_sh_nxt, ctrl_r, ctrl_nxt, len_r, len_nxt;
  logic [13:0] usr_cnt_r, usr_cnt_nxt;
  logic [4:0] asm_cnt_r, asm_cnt_nxt;
  logic [5:0] cmd_cnt_r, cmd_cnt_nxt, cmd_end;
  logic [3:0] ratio_cnt_r, ratio_cnt_nxt, ratio_eff;
  logic [1:0] div_r, div_nxt, fsel, half_cyc;
  logic word_vld_r, word_vld_nxt, lclk_o_r, lclk_o_nxt, cmd_out_r, cmd_out_nxt;
  logic fall_r, fall_nxt, lc_r, lc_nxt, emit, ratio_fault;
  logic req_m, req_s, cs_m, cs_s, lck_m, lck_s, lck_prev_r, usr_m, usr_s, usr_prev_r;
  logic [31:0] dat_m, dat_s;
  logic [3:0] fl_m, fl_s;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;

  wire scheme_flash = ctrl_r[fbl_pkg::CTRL_SCHEME];
  wire [1:0] width = ctrl_r[fbl_pkg::CTRL_WIDTH +: 2];
  wire quad = ctrl_r[fbl_pkg::CTRL_QUAD];
  wire user_sel = ctrl_r[fbl_pkg::CTRL_USRCLK];

  // Pins cross into aclk through two flops before anything looks at them.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {req_m, req_s, cs_m, cs_s} <= 4'hf;
      {lck_m, lck_s, lck_prev_r, usr_m, usr_s, usr_prev_r} <= 6'h00;
      dat_m <= 32'h0000_0000;
      dat_s <= 32'h0000_0000;
      fl_m <= 4'h0;
      fl_s <= 4'h0;
    end
    else
    begin
      {req_m, req_s, cs_m, cs_s} <= {reconfig_request_n, req_m, config_state_n_i, cs_m};
      {lck_m, lck_s, lck_prev_r} <= {load_clock_i, lck_m, lck_s};
      {usr_m, usr_s, usr_prev_r} <= {user_init_clock, usr_m, usr_s};
      dat_m <= load_data;
      dat_s <= dat_m;
      fl_m <= flash_data_lines;
      fl_s <= fl_m;
    end
  end

  // Protected images cannot run at one clock per word.
  always_comb
  begin
    ratio_eff = (ctrl_r[fbl_pkg::CTRL_RATIO +: 4] == 4'h0) ? 4'h1 : ctrl_r[fbl_pkg::CTRL_RATIO +: 4];
    ratio_fault = ctrl_r[fbl_pkg::CTRL_SECURE] && (ratio_eff < 4'h2);
    if (ratio_fault)
      ratio_eff = 4'h2;
    fsel = ctrl_r[fbl_pkg::CTRL_FCLK +: 2];
    if (ctrl_r[fbl_pkg::CTRL_CHAIN] && fsel == fbl_pkg::FL_SEL_TOP)
      fsel = fbl_pkg::FL_SEL_CHAIN;
    case (fsel)
      2'h0: half_cyc = 2'(fbl_pkg::FL_HALF0);
      2'h1: half_cyc = 2'(fbl_pkg::FL_HALF1);
      2'h2: half_cyc = 2'(fbl_pkg::FL_HALF2);
      default: half_cyc = 2'(fbl_pkg::FL_HALF3);
    endcase
    // At a one-cycle half period the synchronised data lines trail by a whole flash clock,
    // so one idle clock is spent between the command and the first captured bit.
    cmd_end = fbl_pkg::CMD_BITS + {5'h00, half_cyc == 2'h1};
  end

  always_comb
  begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    word_cnt_nxt = word_cnt_r;
    asm_nxt = asm_r;
    asm_cnt_nxt = asm_cnt_r;
    word_nxt = word_r;
    cmd_sh_nxt = cmd_sh_r;
    cmd_cnt_nxt = cmd_cnt_r;
    cmd_out_nxt = cmd_out_r;
    usr_cnt_nxt = usr_cnt_r;
    ratio_cnt_nxt = ratio_cnt_r;
    div_nxt = div_r;
    lclk_o_nxt = lclk_o_r;
    word_vld_nxt = 1'b0;
    fall_nxt = 1'b0;
    emit = 1'b0;
    case (state_r)
      fbl_pkg::FBL_RESET:
      begin
        word_cnt_nxt = 32'h0000_0000;
        asm_cnt_nxt = 5'h00;
        ratio_cnt_nxt = 4'h0;
        div_nxt = 2'h0;
        lclk_o_nxt = 1'b0;
        cmd_cnt_nxt = 6'h00;
        cmd_out_nxt = 1'b0;
        cmd_sh_nxt = {fbl_pkg::FLASH_READ_CMD, 24'h00_0000};
        if (tmr_r < 32'(STATUS_MIN_CYC_P))
          tmr_nxt = tmr_r + 32'h1;
        else if (req_s && cs_s)
          state_nxt = fbl_pkg::FBL_LOAD;
      end
      fbl_pkg::FBL_LOAD:
      begin
        if (!scheme_flash)
        begin
          if (lck_s && !lck_prev_r)
          begin
            ratio_cnt_nxt = (ratio_cnt_r >= ratio_eff - 4'h1) ? 4'h0 : ratio_cnt_r + 4'h1;
            if (ratio_cnt_r == 4'h0)
            begin
              asm_cnt_nxt = asm_cnt_r + 5'h01;
              case (width)
                2'h0:
                begin
                  asm_nxt = {dat_s[7:0], asm_r[31:8]};
                  emit = (asm_cnt_r == 5'h03);
                end
                2'h1:
                begin
                  asm_nxt = {dat_s[15:0], asm_r[31:16]};
                  emit = (asm_cnt_r == 5'h01);
                end
                default:
                begin
                  asm_nxt = dat_s;
                  emit = 1'b1;
                end
              endcase
            end
          end
        end
        else if (div_r >= half_cyc - 2'h1)
        begin
          div_nxt = 2'h0;
          lclk_o_nxt = !lclk_o_r;
          if (lclk_o_r)
          begin
            fall_nxt = 1'b1;
            if (cmd_cnt_r != cmd_end)
            begin
              cmd_out_nxt = cmd_sh_r[31];
              cmd_sh_nxt = {cmd_sh_r[30:0], 1'b0};
              cmd_cnt_nxt = cmd_cnt_r + 6'h01;
            end
            else if (quad)
            begin
              asm_nxt = {asm_r[27:0], fl_s};
              asm_cnt_nxt = asm_cnt_r + 5'h01;
              emit = (asm_cnt_r == 5'h07);
            end
            else
            begin
              // In single-line mode the flash answers on line one.
              asm_nxt = {asm_r[30:0], fl_s[1]};
              asm_cnt_nxt = asm_cnt_r + 5'h01;
              emit = (asm_cnt_r == 5'h1f);
            end
          end
        end
        else
          div_nxt = div_r + 2'h1;
        if (emit)
        begin
          asm_cnt_nxt = 5'h00;
          word_nxt = asm_nxt;
          word_vld_nxt = 1'b1;
          word_cnt_nxt = word_cnt_r + 32'h1;
        end
        if (word_cnt_r >= len_r)
        begin
          state_nxt = fbl_pkg::FBL_INIT;
          tmr_nxt = 32'h0000_0000;
          usr_cnt_nxt = 14'h0000;
          lclk_o_nxt = 1'b0;
        end
      end
      fbl_pkg::FBL_INIT:
      begin
        if (tmr_r != 32'hffff_ffff)
          tmr_nxt = tmr_r + 32'h1;
        if (!user_sel)
        begin
          if (tmr_r >= 32'(UM_MIN_CYC_P - 1))
            state_nxt = fbl_pkg::FBL_USER;
        end
        else if (usr_cnt_r == 14'(USR_INIT_EDGES_P))
          state_nxt = fbl_pkg::FBL_USER;
        else if (tmr_r >= 32'(fbl_pkg::CU_CYC) && usr_s && !usr_prev_r)
          usr_cnt_nxt = usr_cnt_r + 14'h0001;
      end
      fbl_pkg::FBL_USER: ;
      default: state_nxt = fbl_pkg::FBL_RESET;
    endcase
    if (!req_s)
    begin
      state_nxt = fbl_pkg::FBL_RESET;
      tmr_nxt = 32'h0000_0000;
    end
    lc_nxt = (state_nxt == fbl_pkg::FBL_INIT) || (state_nxt == fbl_pkg::FBL_USER);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= fbl_pkg::FBL_RESET;
      {tmr_r, word_cnt_r, asm_r, word_r, cmd_sh_r} <= 160'h0;
      {usr_cnt_r, asm_cnt_r, cmd_cnt_r, ratio_cnt_r, div_r} <= 31'h0;
      {word_vld_r, lclk_o_r, cmd_out_r, fall_r, lc_r} <= 5'h00;
    end
    else
    begin
      state_r <= state_nxt;
      {tmr_r, word_cnt_r, asm_r, word_r, cmd_sh_r} <=
        {tmr_nxt, word_cnt_nxt, asm_nxt, word_nxt, cmd_sh_nxt};
      {usr_cnt_r, asm_cnt_r, cmd_cnt_r, ratio_cnt_r, div_r} <=
        {usr_cnt_nxt, asm_cnt_nxt, cmd_cnt_nxt, ratio_cnt_nxt, div_nxt};
      {word_vld_r, lclk_o_r, cmd_out_r, fall_r, lc_r} <=
        {word_vld_nxt, lclk_o_nxt, cmd_out_nxt, fall_nxt, lc_nxt};
    end
  end

  // The status line is released only once the least pulse is met and the request is high.
  assign config_state_n_o = 1'b0;
  assign config_state_n_oe = (state_r == fbl_pkg::FBL_RESET) &&
    (tmr_r < 32'(STATUS_MIN_CYC_P) || !req_s);
  assign load_complete = lc_r;
  assign load_clock_o = lclk_o_r;
  assign load_clock_oe = scheme_flash;
  assign flash_cmd_out = cmd_out_r;
  assign init_done_o = 1'b0;
  assign init_done_oe = ctrl_r[fbl_pkg::CTRL_INITEN] && (state_r != fbl_pkg::FBL_USER);
  assign loaded_word = word_r;
  assign loaded_word_valid = word_vld_r;
  assign user_mode = (state_r == fbl_pkg::FBL_USER);

  assign s_axil_awready = !aw_held_r;
  assign s_axil_wready = !w_held_r;
  assign s_axil_bvalid = bvalid_r;
  assign s_axil_bresp = bresp_r;
  assign s_axil_arready = !rvalid_r;
  assign s_axil_rvalid = rvalid_r;
  assign s_axil_rdata = rdata_r;
  assign s_axil_rresp = rresp_r;

  // Options change mid-load at the writer's risk; nothing is frozen during a load.
  always_comb
  begin
    {aw_held_nxt, awaddr_nxt, w_held_nxt, wdata_nxt, wstrb_nxt} =
      {aw_held_r, awaddr_r, w_held_r, wdata_r, wstrb_r};
    {bvalid_nxt, bresp_nxt, rvalid_nxt, rdata_nxt, rresp_nxt} =
      {bvalid_r, bresp_r, rvalid_r, rdata_r, rresp_r};
    ctrl_nxt = ctrl_r;
    len_nxt = len_r;
    if (s_axil_awvalid && !aw_held_r)
      {aw_held_nxt, awaddr_nxt} = {1'b1, s_axil_awaddr};
    if (s_axil_wvalid && !w_held_r)
      {w_held_nxt, wdata_nxt, wstrb_nxt} = {1'b1, s_axil_wdata, s_axil_wstrb};
    if (bvalid_r && s_axil_bready)
      bvalid_nxt = 1'b0;
    if (aw_held_r && w_held_r && !bvalid_r)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = fbl_pkg::RESP_OKAY;
      for (int i = 0; i < 4; i++)
      begin
        if (wstrb_r[i] && awaddr_r == fbl_pkg::REG_CTRL)
          ctrl_nxt[8*i +: 8] = wdata_r[8*i +: 8];
        if (wstrb_r[i] && awaddr_r == fbl_pkg::REG_LEN)
          len_nxt[8*i +: 8] = wdata_r[8*i +: 8];
      end
      if (awaddr_r != fbl_pkg::REG_CTRL && awaddr_r != fbl_pkg::REG_LEN &&
          awaddr_r != fbl_pkg::REG_STAT && awaddr_r != fbl_pkg::REG_CNT &&
          awaddr_r != fbl_pkg::REG_WORD)
        bresp_nxt = fbl_pkg::RESP_SLVERR;
    end
    if (rvalid_r && s_axil_rready)
      rvalid_nxt = 1'b0;
    if (s_axil_arvalid && !rvalid_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = fbl_pkg::RESP_OKAY;
      case (s_axil_araddr)
        fbl_pkg::REG_CTRL: rdata_nxt = ctrl_r;
        fbl_pkg::REG_LEN: rdata_nxt = len_r;
        fbl_pkg::REG_STAT: rdata_nxt = {27'h0, ratio_fault, state_r};
        fbl_pkg::REG_CNT: rdata_nxt = word_cnt_r;
        fbl_pkg::REG_WORD: rdata_nxt = word_r;
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = fbl_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {aw_held_r, awaddr_r, w_held_r, wdata_r, wstrb_r} <= 46'h0;
      {bvalid_r, bresp_r, rvalid_r, rdata_r, rresp_r} <= 38'h0;
      ctrl_r <= fbl_pkg::CTRL_RST;
      len_r <= fbl_pkg::LEN_RST;
    end
    else
    begin
      {aw_held_r, awaddr_r, w_held_r, wdata_r, wstrb_r} <=
        {aw_held_nxt, awaddr_nxt, w_held_nxt, wdata_nxt, wstrb_nxt};
      {bvalid_r, bresp_r, rvalid_r, rdata_r, rresp_r} <=
        {bvalid_nxt, bresp_nxt, rvalid_nxt, rdata_nxt, rresp_nxt};
      ctrl_r <= ctrl_nxt;
      len_r <= len_nxt;
    end
  end

  a_cd_low: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(req_s) |-> ##[1:CD_MAX_CYC] !load_complete) else $error("load complete stayed high");
  a_st_low: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(req_s) |-> ##[1:CD_MAX_CYC] config_state_n_oe) else $error("status not pulled low");
  a_st_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == fbl_pkg::FBL_RESET && tmr_r < 32'(STATUS_MIN_CYC_P)) |-> config_state_n_oe)
    else $error("status released early");
  a_st_leave: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == fbl_pkg::FBL_RESET && !config_state_n_oe && req_s && cs_s) |=>
    state_r == fbl_pkg::FBL_LOAD) else $error("load phase not entered");
  a_um_osc: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(user_mode) && !user_sel) |-> $past(tmr_r) == 32'(UM_MIN_CYC_P - 1))
    else $error("user mode at wrong time");
  a_um_usr: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(user_mode) && user_sel) |-> $past(usr_cnt_r) == 14'(USR_INIT_EDGES_P))
    else $error("user clock count wrong");
  a_usr_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == fbl_pkg::FBL_INIT && tmr_r < 32'(fbl_pkg::CU_CYC)) |=> $stable(usr_cnt_r))
    else $error("user clock counted too early");
  a_chain_clk: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_r[fbl_pkg::CTRL_CHAIN] |-> fsel != fbl_pkg::FL_SEL_TOP) else $error("chain at top rate");
  a_fl_slow: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == fbl_pkg::FBL_LOAD && scheme_flash && half_cyc == 2'h2 && $changed(lclk_o_r))
    |=> $stable(lclk_o_r)) else $error("flash clock too fast");
  a_fl_fall: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(cmd_out_r) |-> fall_r && !lclk_o_r) else $error("command not on falling edge");
  a_init_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == fbl_pkg::FBL_INIT && ctrl_r[fbl_pkg::CTRL_INITEN]) |-> init_done_oe && !init_done_o)
    else $error("init done released early");
  a_req_rst: assert property (@(posedge aclk) disable iff (!aresetn)
    !req_s |=> state_r == fbl_pkg::FBL_RESET) else $error("request low not honoured");

endmodule : fbl_sequencer
`default_nettype wire

// ---- verification/fbl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbl_host_model (
  input wire logic go,
  input wire logic flash,
  input wire logic [3:0] ratio,
  input wire logic [7:0] nwords,
  input wire logic [31:0] base,
  input wire logic [31:0] mode,
  input wire logic status_wire,
  input wire logic load_clock_o,
  input wire logic flash_cmd_out,
  output logic load_clock_i,
  output logic [31:0] load_data,
  output logic [3:0] flash_data_lines,
  output logic [31:0] cmd_seen
);
  int n;
  int f;
  int b;
  int bw;
  logic [31:0] w;
  initial
  begin
    load_clock_i = 1'b0;
    load_data = 32'h0;
    flash_data_lines = 4'h0;
    cmd_seen = 32'h0;
  end
  // The host clocks only inside a frame, so the link clock stands still between loads.
  always @(posedge status_wire)
  begin
    f = 0;
    cmd_seen = 32'h0;
    if (go && !flash)
    begin
      n = (ratio == 4'h0) ? 1 : int'(ratio);
      bw = (mode[2:1] == 2'h0) ? 4 : (mode[2:1] == 2'h1) ? 2 : 1;
      #2007;
      for (int k = 0; k < nwords * bw * n; k++)
      begin
        if (k % n == 0)
          load_data = (base + 32'(k / n / bw)) >> (32 / bw * (k / n % bw));
        #100 load_clock_i = 1'b1;
        #100 load_clock_i = 1'b0;
      end
      load_data = ~load_data;
    end
  end
  // The flash takes each command bit on the rise that follows the fall launching it.
  always @(posedge load_clock_o)
  begin
    if (f >= 1 && f <= 32)
      cmd_seen = {cmd_seen[30:0], flash_cmd_out};
  end
  // Lines outside the data phase toggle so a stale value is never mistaken for data.
  always @(negedge load_clock_o)
  begin
    f++;
    b = mode[3] ? 8 : 32;
    w = base + 32'((f - 32) / b);
    if (f < 32 || f >= 32 + b * nwords)
      flash_data_lines = ~flash_data_lines;
    else if (mode[3])
      flash_data_lines = w[31 - 4 * ((f - 32) % 8) -: 4];
    else
      flash_data_lines = {2'h0, w[31 - (f - 32) % 32], 1'b0};
  end
endmodule : fbl_host_model
`default_nettype wire

// ---- verification/fbl_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbl_sequencer_test;
  logic aclk = 1'b0, aresetn = 1'b0, reconfig_request_n = 1'b1, user_init_clock = 1'b0;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0, flash = 1'b0;
  logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0, hold_n = 1'b1, go = 1'b0, uclk_on = 1'b0;
  logic [7:0] s_axil_awaddr = 8'h0, s_axil_araddr = 8'h0, nwords = 8'h0;
  logic [31:0] s_axil_wdata = 32'h0, base = 32'h0, mode = 32'h0;
  logic [3:0] s_axil_wstrb = 4'hf, ratio = 4'h1;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic [31:0] s_axil_rdata, load_data, loaded_word, cmd_seen;
  logic config_state_n_o, config_state_n_oe, load_complete, load_clock_i, load_clock_o;
  logic load_clock_oe, flash_cmd_out, init_done_o, init_done_oe, loaded_word_valid, user_mode;
  logic [3:0] flash_data_lines;
  logic config_state_n_i;
  logic [33:0] rq[$];
  logic [33:0] wq[$];
  int num_errors = 0;
  int n_tests = 0;
  int ucnt = 0;
  // Open-drain status wire: low when the device pulls it or the host stretches reset.
  assign config_state_n_i = !(config_state_n_oe && !config_state_n_o) && hold_n;
  always #12.5 aclk = ~aclk;
  fbl_sequencer #(.STATUS_MIN_CYC_P(200), .UM_MIN_CYC_P(10), .USR_INIT_EDGES_P(5))
  i_fbl_sequencer (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
    .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
    .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
    .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .reconfig_request_n,
    .config_state_n_i, .config_state_n_o, .config_state_n_oe, .load_complete, .load_clock_i,
    .load_clock_o, .load_clock_oe, .load_data, .flash_cmd_out, .flash_data_lines,
    .user_init_clock, .init_done_o, .init_done_oe, .loaded_word, .loaded_word_valid, .user_mode);
  fbl_host_model i_fbl_host_model (.go, .flash, .ratio, .nwords, .base, .mode,
    .status_wire(config_state_n_i), .load_clock_o, .flash_cmd_out, .load_clock_i, .load_data,
    .flash_data_lines, .cmd_seen);
  always @(posedge aclk)
  begin
    ucnt <= (ucnt + 1) % 4;
    if (uclk_on && ucnt == 0)
      user_init_clock <= ~user_init_clock;
  end
  task automatic chk(input logic [33:0] exp, input logic [33:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic fail_wait(input int lim);
    chk(34'(lim), 34'h0);
    finish_test();
  endtask : fail_wait
  always @(posedge aclk)
  begin
    if (loaded_word_valid === 1'b1)
      chk(wq.pop_front(), {2'h0, loaded_word});
    if (s_axil_rvalid === 1'b1 && s_axil_rready)
      chk(rq.pop_front(), {s_axil_rresp, s_axil_rdata});
    if (s_axil_bvalid === 1'b1 && s_axil_bready)
      chk(rq.pop_front(), {s_axil_bresp, 32'h0});
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int c;
    c = 0;
    @(posedge aclk);
    rq.push_back({r, 32'h0});
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      c++;
      if (s_axil_awready)
        s_axil_awvalid <= 1'b0;
      if (s_axil_wready)
        s_axil_wvalid <= 1'b0;
    end
    while (s_axil_bvalid !== 1'b1 && c < 50);
    s_axil_bready <= 1'b0;
    if (c >= 50)
      fail_wait(c);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int c;
    c = 0;
    @(posedge aclk);
    rq.push_back({r, d});
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      c++;
      if (s_axil_arready)
        s_axil_arvalid <= 1'b0;
    end
    while (s_axil_rvalid !== 1'b1 && c < 50);
    s_axil_rready <= 1'b0;
    if (c >= 50)
      fail_wait(c);
  endtask : axr
  function automatic logic sig(input int k);
    return k == 0 ? load_complete : k == 1 ? config_state_n_oe : user_mode;
  endfunction : sig
  task automatic wt(input int k, input logic v, input int lim, output int c);
    c = 0;
    while (sig(k) !== v && c < lim)
    begin
      @(posedge aclk);
      c++;
    end
    if (sig(k) !== v)
      fail_wait(lim);
  endtask : wt
  task automatic run(input logic [31:0] ctl, input logic [3:0] n, input int hold);
    int c;
    int t;
    logic [31:0] flt;
    flt = {27'h0, ctl[6] && ctl[15:12] < 4'h2, 4'h0};
    base <= $urandom;
    flash <= ctl[0];
    mode <= ctl;
    ratio <= n;
    nwords <= 8'h4;
    go <= 1'b1;
    uclk_on <= ctl[4];
    axw(fbl_pkg::REG_CTRL, ctl, fbl_pkg::RESP_OKAY);
    axw(fbl_pkg::REG_LEN, 32'h4, fbl_pkg::RESP_OKAY);
    for (int k = 0; k < 4; k++)
      wq.push_back({2'h0, base + 32'(k)});
    @(posedge aclk);
    reconfig_request_n <= 1'b0;
    hold_n <= (hold == 0);
    wt(0, 1'b0, 25, c);
    wt(1, 1'b1, 25, t);
    repeat (80) @(posedge aclk);
    reconfig_request_n <= 1'b1;
    wt(1, 1'b0, 60240, c);
    chk(34'h1, {33'h0, 80 - t + c >= 200});
    if (hold > 0)
    begin
      repeat (hold) @(posedge aclk);
      axr(fbl_pkg::REG_STAT, flt | 32'h1, fbl_pkg::RESP_OKAY);
      hold_n <= 1'b1;
    end
    wt(0, 1'b1, 5000, c);
    chk({32'h0, ctl[5], 1'b0}, {32'h0, init_done_oe, init_done_o});
    chk({33'h0, ctl[0]}, {33'h0, load_clock_oe});
    wt(2, 1'b1, 5000, c);
    if (ctl[4])
      chk(34'h1, {33'h0, c >= 32});
    else
      chk(34'h1, {33'h0, c >= 9 && c <= 12});
    chk(34'h0, {33'h0, init_done_oe});
    axr(fbl_pkg::REG_STAT, flt | 32'h8, fbl_pkg::RESP_OKAY);
    axr(fbl_pkg::REG_CNT, 32'h4, fbl_pkg::RESP_OKAY);
    if (ctl[0])
      chk({2'h0, fbl_pkg::FLASH_READ_CMD, 24'h0}, {2'h0, cmd_seen});
    go <= 1'b0;
    uclk_on <= 1'b0;
  endtask : run
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (90000) @(posedge aclk);
    fail_wait(90000);
  end
  initial
  begin
    void'($urandom(64209));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(fbl_pkg::REG_CTRL, fbl_pkg::CTRL_RST, fbl_pkg::RESP_OKAY);
    axr(fbl_pkg::REG_LEN, fbl_pkg::LEN_RST, fbl_pkg::RESP_OKAY);
    axr(8'h40, 32'h0, fbl_pkg::RESP_SLVERR);
    axw(8'h40, $urandom, fbl_pkg::RESP_SLVERR);
    run(32'h0000_1024, 4'h1, 0);
    run(32'h0000_1044, 4'h2, 40);
    run(32'h0000_103d, 4'h1, 0);
    run(32'h0000_3000, 4'h3, 0);
    run(32'h0000_1012, 4'h1, 0);
    run(32'h0000_1381, 4'h1, 0);
    finish_test();
  end
endmodule : fbl_sequencer_test
`default_nettype wire
